/* pkg/pot_pkg.sv */
package pot_pkg;
    // Register locations
    localparam logic [7:0] LOC_WIPER = 8'h00;
    localparam logic [7:0] LOC_RESERVED = 8'h01;
    localparam logic [7:0] LOC_SELECT = 8'h02;

    // Identification byte
    localparam logic [4:0] ID_PREFIX = 5'h0A;
    localparam int ID_PREFIX_LSB = 3;
    localparam int ID_STRAP_LSB = 1;

    // Selector layout and values
    localparam int SEL_BIT = 7;
    localparam logic [7:0] SELECT_RESET = 8'h00;
    localparam logic [7:0] SELECT_VOLATILE = 8'h80;

    // Reset and stored values
    localparam logic [7:0] WIPER_RESET = 8'h20;
    localparam logic [7:0] STORE_DEFAULT = 8'h40;
    localparam logic [7:0] READ_ZERO = 8'h00;

    // Byte framing
    localparam int BYTE_BITS = 8;
    localparam logic [3:0] BYTE_DONE = 4'h8;

    // Timing
    localparam int CLK_MHZ = 100;
    localparam int WRITE_CYCLE_US = 10;
    localparam int WRITE_CYCLES = WRITE_CYCLE_US * CLK_MHZ;

    typedef enum logic [3:0] {
        ST_LOAD,
        ST_IDLE,
        ST_ID,
        ST_ID_ACK,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_TX,
        ST_TX_ACK,
        ST_WAIT
    } link_state_t;
endpackage

/* logic/line_sync.sv */
`timescale 1ns/10ps
module line_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Asynchronous lines in, synchronised copy out
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_r;

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            meta_r <= RESET_VAL;
            o_sync <= RESET_VAL;
        end
        else
        begin
            meta_r <= i_async;
            o_sync <= meta_r;
        end
    end
endmodule // line_sync

/* logic/nv_store.sv */
`timescale 1ns/10ps
module nv_store #(
    parameter logic [7:0] INIT = pot_pkg::STORE_DEFAULT,
    parameter int unsigned CYCLES = pot_pkg::WRITE_CYCLES
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Write request
    input wire logic i_start,
    input wire logic [7:0] i_data,
    // Stored value and cycle status
    output logic [7:0] o_value,
    output logic o_busy
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);
    localparam logic [CW-1:0] ONE = CW'(1);

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;
    logic [7:0] value_nxt;
    logic busy_nxt;

    always_comb
    begin
        cnt_nxt = cnt_r;
        value_nxt = o_value;
        busy_nxt = o_busy;
        if (o_busy)
        begin
            cnt_nxt = cnt_r - ONE;
            busy_nxt = (cnt_r != ONE);
        end
        else if (i_start)
        begin
            value_nxt = i_data;
            cnt_nxt = LOAD;
            busy_nxt = 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            cnt_r <= '0;
            o_value <= INIT;
            o_busy <= 1'b0;
        end
        else
        begin
            cnt_r <= cnt_nxt;
            o_value <= value_nxt;
            o_busy <= busy_nxt;
        end
    end

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);

    busy_start_a: assert property ((i_start && !o_busy) |=> o_busy && (o_value == $past(i_data)))
        else $error("write cycle did not begin on request");
    busy_end_a: assert property ((o_busy && cnt_r == ONE) |=> !o_busy)
        else $error("write cycle did not end on count");
endmodule // nv_store

/* logic/pot_wiper_i2c_access.sv */
`timescale 1ns/10ps
module pot_wiper_i2c_access #(
    parameter int unsigned WRITE_CYCLES = pot_pkg::WRITE_CYCLES,
    parameter logic [7:0] STORE_INIT = pot_pkg::STORE_DEFAULT
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    // Two-wire bus
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda,
    output logic o_sda_oe,
    // Address straps
    input wire logic i_strap_pin_hi,
    input wire logic i_strap_pin_lo,
    // Wiper and status
    output logic [7:0] o_wiper,
    output logic o_busy
);
    logic rst_b_s;
    logic [3:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic [1:0] strap_s;
    logic scl_d_r;
    logic sda_d_r;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic id_ok;
    logic [7:0] store_value;
    logic [7:0] read_byte;

    pot_pkg::link_state_t state_r;
    pot_pkg::link_state_t state_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [7:0] shift_r;
    logic [7:0] shift_nxt;
    logic [7:0] tx_r;
    logic [7:0] tx_nxt;
    logic [7:0] addr_r;
    logic [7:0] addr_nxt;
    logic rw_r;
    logic rw_nxt;
    logic [7:0] sel_r;
    logic [7:0] sel_nxt;
    logic [7:0] wiper_r;
    logic [7:0] wiper_nxt;
    logic pend_r;
    logic pend_nxt;
    logic [7:0] nvdata_r;
    logic [7:0] nvdata_nxt;
    logic nv_start_r;
    logic nv_start_nxt;
    logic sda_oe_r;
    logic sda_oe_nxt;
    logic sda_out_r;

    // Reset release through two flops
    line_sync #(.WIDTH(1), .RESET_VAL(1'b0)) u_rst_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(i_rst_b),
        .i_async(1'b1),
        .o_sync(rst_b_s)
    );

    // Bus lines and straps into the clock domain
    line_sync #(.WIDTH(4), .RESET_VAL(4'hF)) u_pin_sync (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(rst_b_s),
        .i_async({i_scl, i_sda, i_strap_pin_hi, i_strap_pin_lo}),
        .o_sync(pins_s)
    );

    nv_store #(.INIT(STORE_INIT), .CYCLES(WRITE_CYCLES)) u_store (
        .i_clk_sys(i_clk_sys),
        .i_rst_b(rst_b_s),
        .i_start(nv_start_r),
        .i_data(nvdata_r),
        .o_value(store_value),
        .o_busy(o_busy)
    );

    assign scl_s = pins_s[3];
    assign sda_s = pins_s[2];
    assign strap_s = pins_s[1:0];
    assign scl_rise = scl_s & ~scl_d_r;
    assign scl_fall = ~scl_s & scl_d_r;
    assign start_ev = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign stop_ev = scl_s & scl_d_r & ~sda_d_r & sda_s;
    assign id_ok = (shift_r[7:pot_pkg::ID_PREFIX_LSB] == pot_pkg::ID_PREFIX)
        && (shift_r[pot_pkg::ID_STRAP_LSB +: 2] == strap_s);

    // Byte returned by a read
    always_comb
    begin
        case (addr_r)
            pot_pkg::LOC_WIPER: read_byte = sel_r[pot_pkg::SEL_BIT] ? wiper_r : store_value;
            pot_pkg::LOC_SELECT: read_byte = sel_r;
            default: read_byte = pot_pkg::READ_ZERO;
        endcase
    end

    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        shift_nxt = shift_r;
        tx_nxt = tx_r;
        addr_nxt = addr_r;
        rw_nxt = rw_r;
        sel_nxt = sel_r;
        wiper_nxt = wiper_r;
        pend_nxt = pend_r;
        nvdata_nxt = nvdata_r;
        nv_start_nxt = 1'b0;
        sda_oe_nxt = sda_oe_r;
        if (state_r == pot_pkg::ST_LOAD)
        begin
            wiper_nxt = store_value;
            state_nxt = pot_pkg::ST_IDLE;
        end
        else if (o_busy || nv_start_r)
        begin
            // Bus ignored while the store is written
            state_nxt = pot_pkg::ST_IDLE;
            sda_oe_nxt = 1'b0;
        end
        else if (stop_ev)
        begin
            nv_start_nxt = pend_r;
            pend_nxt = 1'b0;
            state_nxt = pot_pkg::ST_IDLE;
            sda_oe_nxt = 1'b0;
        end
        else if (start_ev)
        begin
            state_nxt = pot_pkg::ST_ID;
            cnt_nxt = '0;
            sda_oe_nxt = 1'b0;
        end
        else
        begin
            case (state_r)
                pot_pkg::ST_ID, pot_pkg::ST_ADDR, pot_pkg::ST_WDATA:
                begin
                    if (scl_rise)
                    begin
                        shift_nxt = {shift_r[6:0], sda_s};
                        cnt_nxt = cnt_r + 4'h1;
                    end
                    else if (scl_fall && cnt_r == pot_pkg::BYTE_DONE)
                    begin
                        cnt_nxt = '0;
                        sda_oe_nxt = 1'b1;
                        if (state_r == pot_pkg::ST_ID)
                        begin
                            if (id_ok)
                            begin
                                rw_nxt = shift_r[0];
                                state_nxt = pot_pkg::ST_ID_ACK;
                            end
                            else
                            begin
                                sda_oe_nxt = 1'b0;
                                state_nxt = pot_pkg::ST_IDLE;
                            end
                        end
                        else if (state_r == pot_pkg::ST_ADDR)
                        begin
                            addr_nxt = shift_r;
                            state_nxt = pot_pkg::ST_ADDR_ACK;
                        end
                        else
                        begin
                            // Data byte takes effect on its last falling edge
                            if (addr_r == pot_pkg::LOC_WIPER)
                            begin
                                wiper_nxt = shift_r;
                                if (!sel_r[pot_pkg::SEL_BIT])
                                begin
                                    pend_nxt = 1'b1;
                                    nvdata_nxt = shift_r;
                                end
                            end
                            else if (addr_r == pot_pkg::LOC_SELECT)
                            begin
                                sel_nxt = shift_r;
                            end
                            state_nxt = pot_pkg::ST_WDATA_ACK;
                        end
                    end
                end
                pot_pkg::ST_ID_ACK:
                begin
                    if (scl_fall)
                    begin
                        cnt_nxt = '0;
                        if (rw_r)
                        begin
                            tx_nxt = read_byte;
                            sda_oe_nxt = ~read_byte[7];
                            state_nxt = pot_pkg::ST_TX;
                        end
                        else
                        begin
                            sda_oe_nxt = 1'b0;
                            state_nxt = pot_pkg::ST_ADDR;
                        end
                    end
                end
                pot_pkg::ST_ADDR_ACK:
                begin
                    if (scl_fall)
                    begin
                        sda_oe_nxt = 1'b0;
                        state_nxt = pot_pkg::ST_WDATA;
                    end
                end
                pot_pkg::ST_WDATA_ACK:
                begin
                    if (scl_fall)
                    begin
                        sda_oe_nxt = 1'b0;
                        state_nxt = pot_pkg::ST_WAIT;
                    end
                end
                pot_pkg::ST_TX:
                begin
                    if (scl_rise)
                    begin
                        cnt_nxt = cnt_r + 4'h1;
                    end
                    else if (scl_fall)
                    begin
                        if (cnt_r == pot_pkg::BYTE_DONE)
                        begin
                            cnt_nxt = '0;
                            sda_oe_nxt = 1'b0;
                            state_nxt = pot_pkg::ST_TX_ACK;
                        end
                        else
                        begin
                            tx_nxt = {tx_r[6:0], 1'b0};
                            sda_oe_nxt = ~tx_r[6];
                        end
                    end
                end
                pot_pkg::ST_TX_ACK:
                begin
                    if (scl_rise)
                    begin
                        shift_nxt = {shift_r[6:0], sda_s};
                    end
                    else if (scl_fall)
                    begin
                        // Master ack repeats the byte, no ack waits for STOP
                        if (!shift_r[0])
                        begin
                            tx_nxt = read_byte;
                            sda_oe_nxt = ~read_byte[7];
                            state_nxt = pot_pkg::ST_TX;
                        end
                        else
                        begin
                            state_nxt = pot_pkg::ST_WAIT;
                        end
                    end
                end
                pot_pkg::ST_IDLE, pot_pkg::ST_WAIT:
                begin
                    sda_oe_nxt = 1'b0;
                end
                default:
                begin
                    state_nxt = pot_pkg::ST_IDLE;
                    sda_oe_nxt = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_b_s)
    begin
        if (!rst_b_s)
        begin
            state_r <= pot_pkg::ST_LOAD;
            cnt_r <= '0;
            shift_r <= '0;
            tx_r <= '0;
            addr_r <= pot_pkg::LOC_WIPER;
            rw_r <= 1'b0;
            sel_r <= pot_pkg::SELECT_RESET;
            wiper_r <= pot_pkg::WIPER_RESET;
            pend_r <= 1'b0;
            nvdata_r <= '0;
            nv_start_r <= 1'b0;
            sda_oe_r <= 1'b0;
            sda_out_r <= 1'b0;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            shift_r <= shift_nxt;
            tx_r <= tx_nxt;
            addr_r <= addr_nxt;
            rw_r <= rw_nxt;
            sel_r <= sel_nxt;
            wiper_r <= wiper_nxt;
            pend_r <= pend_nxt;
            nvdata_r <= nvdata_nxt;
            nv_start_r <= nv_start_nxt;
            sda_oe_r <= sda_oe_nxt;
            sda_out_r <= 1'b0;
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    assign o_sda = sda_out_r;
    assign o_sda_oe = sda_oe_r;
    assign o_wiper = wiper_r;

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!rst_b_s);

    sequence byte_end_s(pot_pkg::link_state_t st);
        state_r == st && scl_fall && cnt_r == pot_pkg::BYTE_DONE && !o_busy && !nv_start_r && !stop_ev && !start_ev;
    endsequence

    sequence ack_drive_s(pot_pkg::link_state_t st);
        state_r == st && sda_oe_r;
    endsequence

    id_accept_a: assert property (byte_end_s(pot_pkg::ST_ID) ##0 id_ok |=> ack_drive_s(pot_pkg::ST_ID_ACK))
        else $error("valid identification not acknowledged");
    id_reject_a: assert property (byte_end_s(pot_pkg::ST_ID) ##0 !id_ok |=> state_r == pot_pkg::ST_IDLE && !sda_oe_r)
        else $error("foreign identification answered");
    addr_ack_a: assert property (byte_end_s(pot_pkg::ST_ADDR) |=> ack_drive_s(pot_pkg::ST_ADDR_ACK))
        else $error("location byte not acknowledged");
    msb_first_a: assert property ((state_r == pot_pkg::ST_ID_ACK && scl_fall && rw_r && !o_busy && !nv_start_r
        && !stop_ev && !start_ev) |=> state_r == pot_pkg::ST_TX && sda_oe_r == ~tx_r[7])
        else $error("read data does not start with its top bit");
    read_select_a: assert property ((state_r == pot_pkg::ST_ID_ACK && rw_r && addr_r == pot_pkg::LOC_WIPER
        && scl_fall && !o_busy && !nv_start_r && !stop_ev && !start_ev)
        |=> tx_r == (sel_r[pot_pkg::SEL_BIT] ? wiper_r : store_value))
        else $error("location 00h read chose the wrong source");
    power_copy_a: assert property ((state_r == pot_pkg::ST_LOAD) |-> sel_r == pot_pkg::SELECT_RESET
        ##1 wiper_r == $past(store_value))
        else $error("power-up copy or selector default missing");
    volatile_only_a: assert property (byte_end_s(pot_pkg::ST_WDATA) ##0 addr_r == pot_pkg::LOC_WIPER
        ##0 sel_r[pot_pkg::SEL_BIT] |=> wiper_r == $past(shift_r) && !pend_r)
        else $error("volatile write touched the store");
    store_write_a: assert property ((pend_r && stop_ev && !o_busy && !nv_start_r)
        |=> nv_start_r ##1 o_busy && o_wiper == store_value)
        else $error("store write not started at stop");
    busy_quiet_a: assert property (o_busy |=> !sda_oe_r && state_r == pot_pkg::ST_IDLE)
        else $error("bus answered during store write");
    read_hold_a: assert property ((state_r == pot_pkg::ST_TX) |=> $stable(wiper_r))
        else $error("wiper changed during a read");
    reserved_zero_a: assert property ((addr_r == pot_pkg::LOC_RESERVED) |-> read_byte == pot_pkg::READ_ZERO
        ##1 $stable(sel_r))
        else $error("reserved location not inert");
endmodule // pot_wiper_i2c_access

/* verification/i2c_master_model.sv */
`timescale 1ns/10ps
module i2c_master_model (
    // Clock
    input wire logic i_clk_sys,
    // Wire level and drives
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_low
);
    initial
    begin
        o_scl = 1'b1;
        o_sda_low = 1'b0;
    end

    // Half of the 80 ns bus period
    task automatic half();
        repeat (4) @(posedge i_clk_sys);
    endtask

    // Start, also repeated start after a low clock
    task automatic start();
        o_sda_low <= 1'b0;
        half();
        o_scl <= 1'b1;
        half();
        o_sda_low <= 1'b1;
        half();
        o_scl <= 1'b0;
        half();
    endtask

    // Stop after the last bit of a transfer
    task automatic stop();
        o_sda_low <= 1'b1;
        half();
        o_scl <= 1'b1;
        half();
        o_sda_low <= 1'b0;
        half();
    endtask

    // One 80 ns bit: data moves mid-way through the low phase, away from both clock edges
    task automatic xfer_bit(input logic b, output logic r);
        o_sda_low <= ~b;
        repeat (2) @(posedge i_clk_sys);
        o_scl <= 1'b1;
        repeat (3) @(posedge i_clk_sys);
        r = i_sda;
        @(posedge i_clk_sys);
        o_scl <= 1'b0;
        repeat (2) @(posedge i_clk_sys);
    endtask

    // Eight bits most significant first, then the acknowledge slot
    task automatic xfer_byte(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--)
            xfer_bit(d[i], q[i]);
        xfer_bit(last, ack);
    endtask
endmodule // i2c_master_model

/* verification/pot_wiper_i2c_access_tb.sv */
`timescale 1ns/10ps
module pot_wiper_i2c_access_tb;
    localparam int WCYC = 200;
    localparam logic [6:0] ID_OK = {pot_pkg::ID_PREFIX, 2'b10};
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic strap_hi = 1'b1;
    logic strap_lo = 1'b0;
    logic scl;
    logic sda_low;
    logic sda_oe;
    logic sda_drv;
    logic busy;
    logic [7:0] wiper;
    wire sda_line;
    int mismatches = 0;
    int checked = 0;
    int busy_cnt = 0;
    logic oe_busy = 1'b0;
    logic ack;
    logic [7:0] q;
    logic [7:0] ids [4] = '{8'h54, 8'h5C, 8'h52, 8'h52};
    logic [3:0] nack_exp = 4'b0110;

    always #5 clk = ~clk;

    // Open-drain wire with pull-up
    assign sda_line = ~(sda_low | (sda_oe & ~sda_drv));

    always @(posedge clk)
    begin
        if (busy === 1'b1)
            busy_cnt <= busy_cnt + 1;
        if (busy === 1'b1 && sda_oe !== 1'b0)
            oe_busy <= 1'b1;
    end

    pot_wiper_i2c_access #(.WRITE_CYCLES(WCYC), .STORE_INIT(pot_pkg::STORE_DEFAULT)) u_pot_wiper_i2c_access (
        .i_clk_sys(clk),
        .i_rst_b(rst_b),
        .i_scl(scl),
        .i_sda(sda_line),
        .o_sda(sda_drv),
        .o_sda_oe(sda_oe),
        .i_strap_pin_hi(strap_hi),
        .i_strap_pin_lo(strap_lo),
        .o_wiper(wiper),
        .o_busy(busy)
    );

    i2c_master_model u_i2c_master_model (
        .i_clk_sys(clk),
        .i_sda(sda_line),
        .o_scl(scl),
        .o_sda_low(sda_low)
    );

    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check8(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            mismatches++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic header(input logic [7:0] loc);
        u_i2c_master_model.start();
        u_i2c_master_model.xfer_byte({ID_OK, 1'b0}, 1'b1, q, ack);
        check8({7'h00, ack}, 8'h00, "id ack");
        u_i2c_master_model.xfer_byte(loc, 1'b1, q, ack);
        check8({7'h00, ack}, 8'h00, "location ack");
    endtask

    task automatic reg_write(input logic [7:0] loc, input logic [7:0] d, input logic [7:0] exp_w);
        header(loc);
        u_i2c_master_model.xfer_byte(d, 1'b1, q, ack);
        check8({7'h00, ack}, 8'h00, "data ack");
        check8(wiper, exp_w, "wiper before stop");
        u_i2c_master_model.stop();
    endtask

    task automatic reg_read(input logic [7:0] loc, input logic [7:0] exp);
        header(loc);
        u_i2c_master_model.start();
        u_i2c_master_model.xfer_byte({ID_OK, 1'b1}, 1'b1, q, ack);
        check8({7'h00, ack}, 8'h00, "read id ack");
        u_i2c_master_model.xfer_byte(8'hFF, 1'b1, q, ack);
        u_i2c_master_model.stop();
        check8(q, exp, "read data");
    endtask

    initial
    begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        repeat (10) @(posedge clk);
        check8(wiper, pot_pkg::STORE_DEFAULT, "power-up wiper");
        reg_read(pot_pkg::LOC_SELECT, pot_pkg::SELECT_RESET);
        reg_read(pot_pkg::LOC_WIPER, pot_pkg::STORE_DEFAULT);
        reg_write(pot_pkg::LOC_SELECT, pot_pkg::SELECT_VOLATILE, pot_pkg::STORE_DEFAULT);
        reg_read(pot_pkg::LOC_SELECT, pot_pkg::SELECT_VOLATILE);
        reg_write(pot_pkg::LOC_WIPER, 8'h5A, 8'h5A);
        reg_read(pot_pkg::LOC_WIPER, 8'h5A);
        reg_write(pot_pkg::LOC_SELECT, pot_pkg::SELECT_RESET, 8'h5A);
        reg_read(pot_pkg::LOC_WIPER, pot_pkg::STORE_DEFAULT);
        check8(wiper, 8'h5A, "wiper after store read");
        // Deliberate use of the reserved location
        reg_write(pot_pkg::LOC_RESERVED, 8'h33, 8'h5A);
        reg_read(pot_pkg::LOC_RESERVED, pot_pkg::READ_ZERO);
        check8(8'(busy_cnt), 8'h00, "no store write yet");
        reg_write(pot_pkg::LOC_WIPER, 8'h77, 8'h77);
        for (int n = 0; n < 50 && busy !== 1'b1; n++)
            @(posedge clk);
        check8({7'h00, busy}, 8'h01, "busy after stop");
        if (busy !== 1'b1)
            stop_test();
        // Addressed traffic while the store write runs
        u_i2c_master_model.start();
        u_i2c_master_model.xfer_byte({ID_OK, 1'b0}, 1'b1, q, ack);
        check8({7'h00, ack}, 8'h01, "ack while busy");
        for (int n = 0; n < WCYC + 50 && busy !== 1'b0; n++)
            @(posedge clk);
        check8({7'h00, busy}, 8'h00, "busy end");
        if (busy !== 1'b0)
            stop_test();
        u_i2c_master_model.stop();
        check8(8'(busy_cnt), 8'(WCYC), "busy length");
        check8({7'h00, oe_busy}, 8'h00, "drive while busy");
        reg_read(pot_pkg::LOC_WIPER, 8'h77);
        // Master ack after the data byte brings the same byte again
        header(pot_pkg::LOC_WIPER);
        u_i2c_master_model.start();
        u_i2c_master_model.xfer_byte({ID_OK, 1'b1}, 1'b1, q, ack);
        check8({7'h00, ack}, 8'h00, "second read id ack");
        u_i2c_master_model.xfer_byte(8'hFF, 1'b0, q, ack);
        check8(q, 8'h77, "first read byte");
        u_i2c_master_model.xfer_byte(8'hFF, 1'b1, q, ack);
        u_i2c_master_model.stop();
        check8(q, 8'h77, "repeated read byte");
        check8(wiper, 8'h77, "wiper after repeated read");
        // Identification bytes against the straps
        for (int i = 0; i < 4; i++)
        begin
            if (i == 3)
            begin
                strap_hi <= 1'b0;
                strap_lo <= 1'b1;
                repeat (8) @(posedge clk);
            end
            u_i2c_master_model.start();
            u_i2c_master_model.xfer_byte(ids[i], 1'b1, q, ack);
            u_i2c_master_model.stop();
            check8({7'h00, ack}, {7'h00, nack_exp[i]}, "id decode");
        end
        stop_test();
    end
endmodule // pot_wiper_i2c_access_tb
